/* File: rtl/eps_pkg.sv */
// Constants, register map and carrier types of the external pin interrupt block
package eps_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_PINS = 12;
	localparam int REG_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int BE_W = 4;
	localparam int SENSE_W = 2 * NUM_PINS;
	localparam int SENSE_HI_W = 8;
	localparam int BYTE_W = 8;
	localparam int SENSE_FIELD_W = 2;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_SENSE_HIGH = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_SENSE_LOW = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_REQ_STATUS = 5'h0C;

	// ----------------------------------------------------------------
	// Field masks and reset values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] ENABLE_MASK = 16'h0FFF;
	localparam logic [REG_W-1:0] SENSE_HIGH_MASK = 16'h00FF;
	localparam logic [REG_W-1:0] SENSE_LOW_MASK = 16'hFFFF;
	localparam logic [REG_W-1:0] STATUS_MASK = 16'h0FFF;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
	localparam logic PIN_IDLE = 1'h1;

	// Sense field bit positions inside one pin's two-bit field
	localparam int SENSE_FALL_BIT = 0;
	localparam int SENSE_RISE_BIT = 1;

	// Sense selections
	typedef enum logic [1:0] {
		SENSE_LOW_LEVEL = 2'h0,
		SENSE_FALLING = 2'h1,
		SENSE_RISING = 2'h2,
		SENSE_BOTH = 2'h3
	} eps_sense_e;

	// ----------------------------------------------------------------
	// Avalon-MM request carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0] byteenable;
	} eps_av_req_s;
endpackage

/* File: rtl/eps_ext_irq.sv */
// External request pin enable, sense selection and request flags
// Contract
// - Per-pin enable bits 11..0, reset zero
// - Reserved upper bits read back as zero
// - Two-bit sense field per pin, rise above fall
// - Sense 00 requests while pin is low
// - Sense 01 requests on falling edge
// - Sense 10 requests on rising edge
// - Sense 11 requests on both edges
// - Sense rewrite may set flag, raising interrupt
// - Per-pin request flags set regardless of enable; enable bits gate only IRQ
`timescale 1ns/1ns
module eps_ext_irq #(
	parameter int NUM_PINS = eps_pkg::NUM_PINS
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire eps_pkg::eps_av_req_s AVS_REQ,
	output logic [eps_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [NUM_PINS-1:0] EXT_REQUEST_PIN_N,
	output logic IRQ
);
	import eps_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte lane merge of a 16-bit register, bits outside the mask stay zero
	function automatic logic [REG_W-1:0] merge16(
		input logic [REG_W-1:0] old_val,
		input logic [DATA_W-1:0] wdata,
		input logic [BE_W-1:0] be,
		input logic [REG_W-1:0] mask
	);
		logic [REG_W-1:0] res;
		res = old_val;
		for (int i = 0; i < REG_W / BYTE_W; i++)
		begin
			if (be[i])
				res[i*BYTE_W +: BYTE_W] = wdata[i*BYTE_W +: BYTE_W];
		end
		return res & mask;
	endfunction

	// Extends a 16-bit register to the bus width
	function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
		return {{(DATA_W-REG_W){1'h0}}, v};
	endfunction

	// Picks one pin's two-bit sense field out of the combined sense word
	function automatic logic [SENSE_FIELD_W-1:0] field_of(
		input logic [SENSE_W-1:0] sense,
		input int pin
	);
		return sense[pin*SENSE_FIELD_W +: SENSE_FIELD_W];
	endfunction

	// Register selected by the bus address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_ENABLE,
		SEL_SENSE_HIGH,
		SEL_SENSE_LOW,
		SEL_STATUS
	} eps_sel_e;

	// Shared by the read and the write path, so the two can never
	// disagree about which offsets are mapped
	function automatic eps_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
		eps_sel_e sel;
		if (addr == OFS_PIN_ENABLE)
			sel = SEL_ENABLE;
		else if (addr == OFS_SENSE_HIGH)
			sel = SEL_SENSE_HIGH;
		else if (addr == OFS_SENSE_LOW)
			sel = SEL_SENSE_LOW;
		else if (addr == OFS_REQ_STATUS)
			sel = SEL_STATUS;
		else
			sel = SEL_NONE;
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [REG_W-1:0] enable_q;
	logic [REG_W-1:0] enable_d;
	logic [REG_W-1:0] sense_hi_q;
	logic [REG_W-1:0] sense_hi_d;
	logic [REG_W-1:0] sense_lo_q;
	logic [REG_W-1:0] sense_lo_d;
	logic [REG_W-1:0] status_q;
	logic [REG_W-1:0] status_d;
	logic [REG_W-1:0] status_clr;
	logic [DATA_W-1:0] readdata_q;
	logic [DATA_W-1:0] read_mux;
	logic waitreq_q;
	logic irq_q;
	logic wr_acc;
	logic rd_load;
	logic [SENSE_W-1:0] sense_now;
	logic [SENSE_W-1:0] sense_next;
	logic [NUM_PINS-1:0] sense_changed;
	logic [NUM_PINS-1:0] pin_hit;
	logic [NUM_PINS-1:0] sync1_q;
	logic [NUM_PINS-1:0] sync2_q;
	logic [NUM_PINS-1:0] sync3_q;
	logic [NUM_PINS-1:0] stable_q;
	logic [REG_W-1:0] hit_ext;
	logic [REG_W-1:0] changed_ext;
	eps_sel_e reg_sel;

	// ----------------------------------------------------------------
	// Avalon-MM handshake
	// ----------------------------------------------------------------
	// Every access sees one wait cycle; the write lands at the edge
	// where the master samples waitrequest low.
	assign wr_acc = AVS_REQ.write && !waitreq_q;
	assign rd_load = AVS_REQ.read && waitreq_q;
	assign reg_sel = reg_decode(AVS_REQ.address);

	always_ff @(posedge CLK)
	begin
		if (RESET)
			waitreq_q <= 1'h1;
		else if ((AVS_REQ.read || AVS_REQ.write) && waitreq_q)
			waitreq_q <= 1'h0;
		else
			waitreq_q <= 1'h1;
	end

	always_comb
	begin
		read_mux = READ_ZERO;
		if (reg_sel == SEL_ENABLE)
			read_mux = widen(enable_q & ENABLE_MASK);
		else if (reg_sel == SEL_SENSE_HIGH)
			read_mux = widen(sense_hi_q & SENSE_HIGH_MASK);
		else if (reg_sel == SEL_SENSE_LOW)
			read_mux = widen(sense_lo_q & SENSE_LOW_MASK);
		else if (reg_sel == SEL_STATUS)
			read_mux = widen(status_q & STATUS_MASK);
		else
			read_mux = READ_ZERO;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			readdata_q <= READ_ZERO;
		else if (rd_load)
			readdata_q <= read_mux;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_comb
	begin
		enable_d = enable_q;
		sense_hi_d = sense_hi_q;
		sense_lo_d = sense_lo_q;
		status_clr = REG_RESET;
		if (wr_acc)
		begin
			if (reg_sel == SEL_ENABLE)
				enable_d = merge16(enable_q, AVS_REQ.writedata, AVS_REQ.byteenable,
					ENABLE_MASK);
			else if (reg_sel == SEL_SENSE_HIGH)
				sense_hi_d = merge16(sense_hi_q, AVS_REQ.writedata, AVS_REQ.byteenable,
					SENSE_HIGH_MASK);
			else if (reg_sel == SEL_SENSE_LOW)
				sense_lo_d = merge16(sense_lo_q, AVS_REQ.writedata, AVS_REQ.byteenable,
					SENSE_LOW_MASK);
			else if (reg_sel == SEL_STATUS)
				status_clr = merge16(REG_RESET, AVS_REQ.writedata, AVS_REQ.byteenable,
					STATUS_MASK);
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			enable_q <= REG_RESET;
		else
			enable_q <= enable_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sense_hi_q <= REG_RESET;
			sense_lo_q <= REG_RESET;
		end
		else
		begin
			sense_hi_q <= sense_hi_d;
			sense_lo_q <= sense_lo_d;
		end
	end

	// Pins 11..8 in the high register, 7..0 in the low register
	assign sense_now = {sense_hi_q[SENSE_HI_W-1:0], sense_lo_q};
	assign sense_next = {sense_hi_d[SENSE_HI_W-1:0], sense_lo_d};

	// ----------------------------------------------------------------
	// Pin synchronisers and sense detection
	// ----------------------------------------------------------------
	// A change counts only once stages two and three agree, so a
	// single-cycle glitch past the first stage is filtered out.
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sync1_q <= {NUM_PINS{PIN_IDLE}};
			sync2_q <= {NUM_PINS{PIN_IDLE}};
			sync3_q <= {NUM_PINS{PIN_IDLE}};
		end
		else
		begin
			sync1_q <= EXT_REQUEST_PIN_N;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_pin
			logic stable_d;
			logic fell;
			logic rose;
			eps_sense_e mode;

			assign stable_d = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi]
				: stable_q[gi];
			assign fell = stable_q[gi] && !stable_d;
			assign rose = !stable_q[gi] && stable_d;
			assign mode = eps_sense_e'(field_of(sense_now, gi));

			always_ff @(posedge CLK)
			begin
				if (RESET)
					stable_q[gi] <= PIN_IDLE;
				else
					stable_q[gi] <= stable_d;
			end

			always_comb
			begin
				case (mode)
					SENSE_LOW_LEVEL: pin_hit[gi] = !stable_q[gi];
					SENSE_FALLING: pin_hit[gi] = fell;
					SENSE_RISING: pin_hit[gi] = rose;
					SENSE_BOTH: pin_hit[gi] = fell || rose;
					default: pin_hit[gi] = 1'h0;
				endcase
			end

			// Any rewrite that alters this pin's field sets its flag
			assign sense_changed[gi] = field_of(sense_next, gi)
				!= field_of(sense_now, gi);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Request flags and interrupt output
	// ----------------------------------------------------------------
	assign hit_ext = {{(REG_W-NUM_PINS){1'h0}}, pin_hit};
	assign changed_ext = {{(REG_W-NUM_PINS){1'h0}}, sense_changed};

	// Set wins over a write-one clear in the same cycle, so an event is
	// never lost; a held low level therefore re-sets its flag at once.
	assign status_d = ((status_q & ~status_clr) | hit_ext | changed_ext)
		& STATUS_MASK;

	always_ff @(posedge CLK)
	begin
		if (RESET)
			status_q <= REG_RESET;
		else
			status_q <= status_d;
	end

	// Enable bits act as the interrupt mask; the sense-rewrite flag
	// raises the line too if the pin is enabled, which is why software
	// disables the pin first and clears the flag before re-enabling.
	always_ff @(posedge CLK)
	begin
		if (RESET)
			irq_q <= 1'h0;
		else
			irq_q <= |(status_q & enable_q);
	end

	assign AVS_READDATA = readdata_q;
	assign AVS_WAITREQUEST = waitreq_q;
	assign IRQ = irq_q;
endmodule

/* File: tb/eps_ext_irq_properties.sv */
// Port assertions of the external pin interrupt block
`timescale 1ns/1ns
module eps_ext_irq_checker #(
	parameter int NUM_PINS = 12
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire eps_pkg::eps_av_req_s AVS_REQ,
	input wire logic [eps_pkg::DATA_W-1:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [NUM_PINS-1:0] EXT_REQUEST_PIN_N,
	input wire logic IRQ
);
	import eps_pkg::*;
	logic rd_done;
	logic rd_take;
	logic [ADDR_W-1:0] a;
	assign rd_done = AVS_REQ.read && !AVS_WAITREQUEST;
	assign rd_take = AVS_REQ.read && AVS_WAITREQUEST;
	assign a = AVS_REQ.address;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	// --------
	// Bus and register checks
	// --------
	property p_wait_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	a_wait_one: assert property (p_wait_one) else $error("long wait low");
	property p_wait_ans; (AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("no answer");
	property p_rsv_en; rd_done && a == OFS_PIN_ENABLE |-> AVS_READDATA[31:12] == 20'h00000; endproperty
	a_rsv_en: assert property (p_rsv_en) else $error("enable high bits");
	property p_rsv_hi; rd_done && a == OFS_SENSE_HIGH |-> AVS_READDATA[31:8] == 24'h000000; endproperty
	a_rsv_hi: assert property (p_rsv_hi) else $error("sense high bits");
	property p_unmap; rd_done && a > OFS_REQ_STATUS |-> AVS_READDATA == READ_ZERO; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_hold; !$stable(AVS_READDATA) |-> $past(rd_take); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst; disable iff (1'h0) RESET |=> AVS_WAITREQUEST && !IRQ; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_gate; rd_done && a == OFS_PIN_ENABLE && AVS_READDATA[11:0] == 12'h000 |-> !IRQ ##1 !IRQ; endproperty
	a_gate: assert property (p_gate) else $error("irq while disabled");
	c_read: cover property (rd_done);
	c_write: cover property (AVS_REQ.write && !AVS_WAITREQUEST);
	c_irq: cover property ($rose(IRQ));
endmodule
bind eps_ext_irq eps_ext_irq_checker #(.NUM_PINS(NUM_PINS)) chk (.CLK(CLK), .RESET(RESET),
	.AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.EXT_REQUEST_PIN_N(EXT_REQUEST_PIN_N), .IRQ(IRQ));

/* File: tb/eps_pin_src.sv */
// Behavioural source of the active-low request pins
`timescale 1ns/1ns
module eps_pin_src (
	output logic [eps_pkg::NUM_PINS-1:0] pin_n
);
	import eps_pkg::*;
	// Pulled up, so an idle pin rests high
	initial pin_n = '1;
	task drive(input int p, input logic v);
		pin_n[p] <= v;
	endtask
endmodule

/* File: tb/ext_pin_irq_enable_sense_tb.sv */
// Self-checking bench of the external pin interrupt block
`timescale 1ns/1ns
module ext_pin_irq_enable_sense_tb;
	import eps_pkg::*;
	logic CLK;
	logic RESET;
	eps_av_req_s req;
	logic [DATA_W-1:0] rd;
	logic [DATA_W-1:0] q;
	logic wr;
	logic [BE_W-1:0] be;
	logic irq;
	logic [NUM_PINS-1:0] pin_n;
	int fails;
	int check_count;
	logic [ADDR_W-1:0] ofs [5] = '{OFS_PIN_ENABLE, OFS_SENSE_HIGH, OFS_SENSE_LOW,
		OFS_REQ_STATUS, 5'h10};
	logic [REG_W-1:0] msk [3] = '{ENABLE_MASK, SENSE_HIGH_MASK, SENSE_LOW_MASK};
	eps_ext_irq uut (.CLK(CLK), .RESET(RESET), .AVS_REQ(req), .AVS_READDATA(rd),
		.AVS_WAITREQUEST(wr), .EXT_REQUEST_PIN_N(pin_n), .IRQ(irq));
	eps_pin_src src (.pin_n(pin_n));
	initial
	begin
		CLK = 1'h0;
		forever #20 CLK = ~CLK;
	end
	// --------
	// Checking and bus tasks
	// --------
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chk_irq(input logic exp);
		chk_reg({31'h0, irq}, {31'h0, exp});
	endtask
	// Request held until waitrequest is seen low; one idle edge keeps drivers apart
	task bus(input logic w, input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] d);
		int n;
		n = 0;
		req <= '{read: !w, write: w, address: ad, writedata: {16'h0000, d}, byteenable: be};
		do
		begin
			@(posedge CLK);
			n++;
			if (n > 20)
			begin
				fails++;
				report_and_stop();
			end
		end
		while (wr !== 1'h0);
		q = rd;
		req <= '0;
		@(posedge CLK);
	endtask
	// Flag after fall, after clear while low, after rise
	function automatic logic want(input int m, input int ph);
		return ph == 0 ? m != 2 : (ph == 1 ? m == 0 : m != 1);
	endfunction
	initial
	begin
		int m;
		int p;
		logic en;
		logic f;
		RESET = 1'h1;
		req = '0;
		be = 4'hF;
		fails = 0;
		check_count = 0;
		p = $urandom(32'hA77C);
		repeat (3) @(posedge CLK);
		RESET <= 1'h0;
		@(posedge CLK);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'h0, ofs[i], 16'h0000);
			chk_reg(q, READ_ZERO);
		end
		bus(1'h1, ofs[4], 16'hFFFF);
		bus(1'h0, ofs[4], 16'h0000);
		chk_reg(q, READ_ZERO);
		$display("test 1 done");
		for (int i = 0; i < 3; i++)
			bus(1'h1, ofs[i], 16'hFFFF);
		for (int i = 0; i < 3; i++)
		begin
			bus(1'h0, ofs[i], 16'h0000);
			chk_reg(q, {16'h0000, msk[i]});
		end
		bus(1'h0, OFS_REQ_STATUS, 16'h0000);
		chk_reg(q, {16'h0000, STATUS_MASK});
		chk_irq(1'h1);
		be = 4'h1;
		bus(1'h1, OFS_SENSE_LOW, 16'h0000);
		be = 4'hF;
		bus(1'h0, OFS_SENSE_LOW, 16'h0000);
		chk_reg(q, 32'h0000FF00);
		$display("test 2 done");
		for (int k = 0; k < 8; k++)
		begin
			m = k / 2;
			p = $urandom % NUM_PINS;
			en = 1'($urandom);
			bus(1'h1, OFS_PIN_ENABLE, 16'h0000);
			bus(1'h1, OFS_SENSE_HIGH, {8'h00, {4{m[1:0]}}});
			bus(1'h1, OFS_SENSE_LOW, {8{m[1:0]}});
			bus(1'h1, OFS_REQ_STATUS, STATUS_MASK);
			bus(1'h1, OFS_PIN_ENABLE, 16'(en) << p);
			for (int ph = 0; ph < 3; ph++)
			begin
				if (ph == 1)
					bus(1'h1, OFS_REQ_STATUS, STATUS_MASK);
				else
					src.drive(p, ph == 2);
				repeat (6 + $urandom % 4) @(posedge CLK);
				f = want(m, ph);
				bus(1'h0, OFS_REQ_STATUS, 16'h0000);
				chk_reg(q, 32'(f) << p);
				chk_irq(f & en);
			end
		end
		$display("test 3 done");
		report_and_stop();
	end
endmodule
